// >>> verification/edge_pin_model.sv
// Behavioural model of the two edge input pins and of the watcher on the timer output pin.
`timescale 1ns/1ps
`default_nettype none
module edge_pin_model (
	input  wire logic pclk,          // Count clock.
	input  wire logic timer_out_pin, // Timer output, watched for toggles.
	output logic      edge_in_a,     // First edge input.
	output logic      edge_in_b,     // Second edge input.
	output var int    toggles        // Output toggles seen so far.
);
	logic out_prev;

	// Both pins rest low, so that no rising edge is seen right after reset.
	initial begin
		edge_in_a = 1'b0;
		edge_in_b = 1'b0;
		toggles = 0;
		out_prev = 1'b0;
	end

	// One pulse: six clocks high, six low, well over two count clocks each way.
	task automatic pulse(input bit on_b);
		@(posedge pclk);
		if (on_b)
			edge_in_b <= 1'b1;
		else
			edge_in_a <= 1'b1;
		repeat (6) @(posedge pclk);
		edge_in_a <= 1'b0;
		edge_in_b <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask

	// Every change of the output level counts as one toggle.
	always @(posedge pclk) begin
		if (timer_out_pin !== out_prev)
			toggles++;
		out_prev <= timer_out_pin;
	end
endmodule
`default_nettype wire

// >>> verification/timer_mode_capture_ctrl_test.sv
// Self-checking testbench of the timer mode and capture control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module timer_mode_capture_ctrl_test;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata, rd_last;
	logic        pready, pslverr, edge_in_a, edge_in_b, timer_out_pin;
	logic [1:0]  capcmp_irq;
	logic [33:0] exp_q[$];
	logic [33:0] note;
	int          n_errors, checked, irq_a, irq_b, toggles;

	timer_mode_capture_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .edge_in_a(edge_in_a), .edge_in_b(edge_in_b),
		.timer_out_pin(timer_out_pin), .capcmp_irq(capcmp_irq));
	edge_pin_model u_pins (.pclk(pclk), .timer_out_pin(timer_out_pin), .edge_in_a(edge_in_a),
		.edge_in_b(edge_in_b), .toggles(toggles));

	// The clock runs at 40 MHz.
	always #12.5 pclk = ~pclk;

	// One APB transfer; the note of its expected answer goes on the queue at setup.
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
		input logic [33:0] nt);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= 32'(idx) << timer_pkg::addr_shift;
		pwdata <= wd;
		exp_q.push_back(nt);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_last = prdata;
		if (n >= 20)
			n_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 34'h0);
	endtask

	task automatic rd(input logic [15:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0, {2'b10, e});
	endtask

	// Stopping before any control write keeps the software side of the contract.
	// No low-power stop mode is ever entered, and never while running.
	task automatic setup(input logic [31:0] es, input logic [31:0] cc, input logic [15:0] ca,
		input logic [31:0] md);
		wr(timer_pkg::mode_ctl_idx, 32'h0);
		wr(timer_pkg::edge_sel_idx, es);
		wr(timer_pkg::capcmp_ctl_idx, cc);
		wr(timer_pkg::capcmp_a_idx, 32'(ca));
		wr(timer_pkg::capcmp_b_idx, 32'h0000ffff);
		wr(timer_pkg::mode_ctl_idx, md);
		repeat (4) @(posedge pclk);
	endtask

	// Watcher: each answer takes the oldest note and is compared against it.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			if (exp_q.size() == 0)
				n_errors++;
			else begin
				note = exp_q.pop_front();
				`CHK("pslverr", note[32], pslverr)
				if (note[33])
					`CHK("prdata", note[31:0], prdata)
			end
		end
	end

	// Interrupt pulses are counted per register.
	always @(posedge pclk) begin
		if (capcmp_irq[0] === 1'b1)
			irq_a++;
		if (capcmp_irq[1] === 1'b1)
			irq_b++;
	end

	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog sized above the long overflow run.
	initial begin
		repeat (90000) @(posedge pclk);
		n_errors++;
		summarize();
	end

	initial begin
		timer_pkg::edge_sel_type sels[3] = '{timer_pkg::edge_fall, timer_pkg::edge_rise,
			timer_pkg::edge_both};
		int          exp_b[3] = '{1, 1, 2};
		bit          trg[3] = '{1'b0, 1'b1, 1'b1};
		bit          onb[3] = '{1'b1, 1'b0, 1'b0};
		int          exp_a[3] = '{1, 1, 0};
		int          base, t0;
		logic [15:0] lim;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		n_errors = 0;
		checked = 0;
		irq_a = 0;
		irq_b = 0;
		void'($urandom(32'h7b5d));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(timer_pkg::mode_ctl_idx, 32'h0);
		rd(timer_pkg::capcmp_ctl_idx, 32'h0);
		apb(1'b0, 16'hff61, 32'h0, {2'b11, 32'h0});
		// Stopped: edges on both pins with capture selected must stay silent.
		setup(32'h000000f0, 32'h5, 16'hffff, 32'h0);
		base = irq_a + irq_b;
		u_pins.pulse(1'b0);
		u_pins.pulse(1'b1);
		`CHK("irq while stopped", base, irq_a + irq_b)
		rd(timer_pkg::count_idx, 32'h0);
		// Every legal edge code on input a, seen as capture interrupts of capcmp_b.
		for (int i = 0; i < 3; i++) begin
			setup({24'h0, 2'b00, sels[i], 4'h0}, 32'h4, 16'hffff, 32'h4);
			base = irq_b;
			u_pins.pulse(1'b0);
			repeat (8) @(posedge pclk);
			`CHK("capture b irqs", exp_b[i], irq_b - base)
		end
		// capcmp_a capture trigger: input b edge, opposite edge of a, none with both edges.
		for (int i = 0; i < 3; i++) begin
			setup({24'h0, 2'b00, sels[i], 4'h0}, {30'h0, trg[i], 1'b1}, 16'hffff, 32'h4);
			base = irq_a;
			u_pins.pulse(onb[i]);
			repeat (8) @(posedge pclk);
			`CHK("capture a irqs", exp_a[i], irq_a - base)
		end
		// Free running passes a match without clearing.
		setup(32'h0, 32'h0, 16'h0010, 32'h4);
		repeat (60) @(posedge pclk);
		apb(1'b0, timer_pkg::count_idx, 32'h0, 34'h0);
		`CHK("free past match", 1'b1, rd_last[15:0] > 16'h0010)
		// Match-clear with a random limit: count bounded, output and interrupt follow matches.
		lim = 16'(8 + $urandom % 32);
		setup(32'h0, 32'h0, lim, 32'hc);
		t0 = toggles;
		base = irq_a;
		repeat (10 * (int'(lim) + 1)) @(posedge pclk);
		`CHK("match irqs", 1'b1, irq_a - base >= 8)
		`CHK("output toggles", 1'b1, toggles - t0 >= 8)
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, timer_pkg::count_idx, 32'h0, 34'h0);
			`CHK("count bound", 1'b1, rd_last[15:0] <= lim)
		end
		// Edge-clear: a rising edge on input a restarts a long-running count.
		setup(32'h10, 32'h0, 16'hffff, 32'h8);
		repeat (200) @(posedge pclk);
		u_pins.pulse(1'b0);
		apb(1'b0, timer_pkg::count_idx, 32'h0, 34'h0);
		`CHK("count restart", 1'b1, rd_last[15:0] < 16'd40)
		// Overflow after a full wrap, then a clear while running keeps the mode bits.
		setup(32'h0, 32'h0, 16'hffff, 32'h4);
		repeat (65576) @(posedge pclk);
		rd(timer_pkg::mode_ctl_idx, 32'h5);
		wr(timer_pkg::mode_ctl_idx, 32'h4);
		rd(timer_pkg::mode_ctl_idx, 32'h4);
		summarize();
	end
endmodule
`default_nettype wire

// >>> verilog/edge_qualify.sv
// Noise-filtered valid-edge and opposite-edge detector for one timer input pin.
`timescale 1ns/1ps
`default_nettype none
module edge_qualify (
	input  wire logic                    pclk,     // Count clock.
	input  wire logic                    presetn,  // Asynchronous reset, active low.
	input  wire logic                    pin,      // Input pin level.
	input  wire timer_pkg::edge_sel_type sel,      // Valid-edge selection.
	output var  timer_pkg::edge_evt_type evt       // Registered edge pulses.
);
	logic samp_q;
	logic lvl_q;
	logic rise;
	logic fall;

	// A level counts only when sampled equal twice; short glitches are dropped.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_q <= 1'b0;
			lvl_q  <= 1'b0;
		end else begin
			samp_q <= pin;
			if (pin == samp_q) begin
				lvl_q <= samp_q;
			end
		end
	end

	assign rise = (pin == samp_q) && samp_q && !lvl_q;
	assign fall = (pin == samp_q) && !samp_q && lvl_q;

	// Both-edge selection has no opposite phase, so that pulse stays low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt <= '0;
		end else begin
			unique case (sel)
				timer_pkg::edge_fall: evt <= '{valid: fall, opposite: rise};
				timer_pkg::edge_rise: evt <= '{valid: rise, opposite: fall};
				timer_pkg::edge_both: evt <= '{valid: rise | fall, opposite: 1'b0};
				default:              evt <= '0;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> verilog/timer_mode_capture_ctrl.sv
// Mode control, capture/compare control and APB registers of a 16-bit timer/event counter.
`timescale 1ns/1ps
`default_nettype none
module timer_mode_capture_ctrl (
	input  wire logic        pclk,          // Count clock, 40 MHz.
	input  wire logic        presetn,       // Asynchronous reset, active low.
	input  wire logic        psel,          // APB select.
	input  wire logic        penable,       // APB access phase.
	input  wire logic        pwrite,        // APB write direction.
	input  wire logic [31:0] paddr,         // APB byte address.
	input  wire logic [31:0] pwdata,        // APB write data.
	output logic      [31:0] prdata,        // APB read data.
	output logic             pready,        // APB ready.
	output logic             pslverr,       // APB error on unmapped address.
	input  wire logic        edge_in_a,     // First external edge input.
	input  wire logic        edge_in_b,     // Second external edge input.
	output logic             timer_out_pin, // Timer output.
	output logic      [1:0]  capcmp_irq     // Interrupts of capcmp_a (bit 0) and capcmp_b.
);
	timer_pkg::mode_ctl_type   mode_q;
	timer_pkg::capcmp_ctl_type cc_ctl_q;
	timer_pkg::edge_sel_type   edge_a_sel_q;
	timer_pkg::edge_sel_type   edge_b_sel_q;
	timer_pkg::edge_evt_type   evt_a;
	timer_pkg::edge_evt_type   evt_b;
	logic [15:0] count_value_q;
	logic [15:0] count_value_d;
	logic [15:0] capcmp_a_q;
	logic [15:0] capcmp_b_q;
	logic        ovf_window_q;
	logic [1:0]  irq_pend_q;
	logic        running;
	logic        match_a;
	logic        match_b;
	logic        cap_a;
	logic        cap_b;
	logic        clear_cnt;
	logic        wrap_ovf;
	logic        toggle_ev;
	logic        wr_en;
	logic        rd_setup;
	logic [5:0]  wr_sel;

	// Decodes a byte address against a register index.
	function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
		hit = (addr == ({16'h0000, idx} << timer_pkg::addr_shift));
	endfunction

	// Edge detectors for both input pins.
	edge_qualify u_edge_a (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (edge_in_a),
		.sel     (edge_a_sel_q),
		.evt     (evt_a)
	);

	edge_qualify u_edge_b (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (edge_in_b),
		.sel     (edge_b_sel_q),
		.evt     (evt_b)
	);

	// Register decode; writes land at the access-phase edge with pready high.
	assign wr_en    = psel && penable && pwrite && pready;
	assign rd_setup = psel && !penable;
	assign wr_sel   = {hit(paddr, timer_pkg::edge_sel_idx), hit(paddr, timer_pkg::capcmp_b_idx),
	                   hit(paddr, timer_pkg::capcmp_a_idx), hit(paddr, timer_pkg::count_idx),
	                   hit(paddr, timer_pkg::capcmp_ctl_idx), hit(paddr, timer_pkg::mode_ctl_idx)}
	                  & {6{wr_en}};

	// Any nonzero mode bits run the counter.
	assign running   = (mode_q.mode != timer_pkg::mode_stop);
	// A register only compares when set to compare mode.
	assign match_a   = running && !cc_ctl_q.capcmp_a_mode && (count_value_q == capcmp_a_q);
	assign match_b   = running && !cc_ctl_q.capcmp_b_mode && (count_value_q == capcmp_b_q);
	// Trigger source of capcmp_a: input b valid edge, or input a opposite edge.
	assign cap_a     = running && cc_ctl_q.capcmp_a_mode
	                   && (cc_ctl_q.capcmp_a_trig_sel ? evt_a.opposite : evt_b.valid);
	assign cap_b     = running && cc_ctl_q.capcmp_b_mode && evt_a.valid;
	// Clear sources depend on mode; free-run ignores matches.
	assign clear_cnt = ((mode_q.mode == timer_pkg::mode_edge) && evt_a.valid)
	                   || ((mode_q.mode == timer_pkg::mode_match) && match_a);
	// Overflow needs capcmp_a at maximum and a wrap from maximum.
	assign wrap_ovf  = running && (capcmp_a_q == timer_pkg::count_max)
	                   && (count_value_q == timer_pkg::count_max);
	// Output toggles in modes 01 and 11 only.
	assign toggle_ev = running && (mode_q.mode != timer_pkg::mode_edge)
	                   && (match_a || match_b || (mode_q.out_toggle_sel && evt_a.valid));

	// Next count: held at zero when stopped, cleared on clear events, else wraps.
	always_comb begin
		if (!running) begin
			count_value_d = timer_pkg::word_reset;
		end else if (clear_cnt) begin
			count_value_d = timer_pkg::word_reset;
		end else begin
			count_value_d = count_value_q + timer_pkg::count_one;
		end
	end

	// Counter register; held at zero while stopped, and software writes to it are ignored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value_q <= timer_pkg::word_reset;
		end else if (running) begin
			count_value_q <= count_value_d;
		end else begin
			count_value_q <= timer_pkg::word_reset;
		end
	end

	// Mode control; an overflow in the same cycle as a clearing write wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= timer_pkg::mode_ctl_type'(timer_pkg::ctl_reset[3:0]);
		end else begin
			if (wr_sel[0]) begin
				mode_q.mode           <= timer_pkg::mode_type'(pwdata[timer_pkg::mode_lo_pos +: 2]);
				mode_q.out_toggle_sel <= pwdata[timer_pkg::out_toggle_pos];
				mode_q.overflow_flag  <= pwdata[timer_pkg::ovf_pos] || wrap_ovf || ovf_window_q;
			end else if (wrap_ovf || ovf_window_q) begin
				mode_q.overflow_flag  <= 1'b1;
			end
		end
	end

	// The re-set window lasts from the wrap until the count leaves 0000H.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_window_q <= 1'b0;
		end else begin
			ovf_window_q <= wrap_ovf || (ovf_window_q && running
			                && (count_value_d == timer_pkg::word_reset));
		end
	end

	// Capture/compare control and edge selection; cleared by reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cc_ctl_q     <= timer_pkg::capcmp_ctl_type'(timer_pkg::ctl_reset[2:0]);
			edge_a_sel_q <= timer_pkg::edge_fall;
			edge_b_sel_q <= timer_pkg::edge_fall;
		end else begin
			if (wr_sel[1]) begin
				cc_ctl_q.capcmp_b_mode     <= pwdata[timer_pkg::cc_b_mode_pos];
				cc_ctl_q.capcmp_a_trig_sel <= pwdata[timer_pkg::cc_a_trig_pos];
				cc_ctl_q.capcmp_a_mode     <= pwdata[timer_pkg::cc_a_mode_pos];
			end
			if (wr_sel[5]) begin
				edge_a_sel_q <= timer_pkg::edge_sel_type'(pwdata[timer_pkg::edge_a_pos +: 2]);
				edge_b_sel_q <= timer_pkg::edge_sel_type'(pwdata[timer_pkg::edge_b_pos +: 2]);
			end
		end
	end

	// Capture/compare words: software loads them, capture events store the count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capcmp_a_q <= timer_pkg::word_reset;
			capcmp_b_q <= timer_pkg::word_reset;
		end else begin
			if (cap_a) begin
				capcmp_a_q <= count_value_q;
			end else if (wr_sel[3]) begin
				capcmp_a_q <= pwdata[15:0];
			end
			if (cap_b) begin
				capcmp_b_q <= count_value_q;
			end else if (wr_sel[4]) begin
				capcmp_b_q <= pwdata[15:0];
			end
		end
	end

	// The interrupt trails its cause by two count clocks, one after the capture stores the count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pend_q <= 2'b00;
			capcmp_irq <= 2'b00;
		end else begin
			irq_pend_q <= {match_b || cap_b, match_a || cap_a};
			capcmp_irq <= irq_pend_q & {2{running}};
		end
	end

	// Output flip-flop; mode 10 leaves it unchanged.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_out_pin <= 1'b0;
		end else if (toggle_ev) begin
			timer_out_pin <= !timer_out_pin;
		end
	end

	// APB slave with no wait state; read data is latched in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= timer_pkg::rdata_reset;
		end else begin
			pready  <= rd_setup;
			pslverr <= rd_setup && !(hit(paddr, timer_pkg::mode_ctl_idx)
			           || hit(paddr, timer_pkg::capcmp_ctl_idx) || hit(paddr, timer_pkg::count_idx)
			           || hit(paddr, timer_pkg::capcmp_a_idx) || hit(paddr, timer_pkg::capcmp_b_idx)
			           || hit(paddr, timer_pkg::edge_sel_idx));
			if (rd_setup && !pwrite) begin
				if (hit(paddr, timer_pkg::mode_ctl_idx)) begin
					prdata <= {28'h0000000, mode_q};
				end else if (hit(paddr, timer_pkg::capcmp_ctl_idx)) begin
					prdata <= {29'h0, cc_ctl_q};
				end else if (hit(paddr, timer_pkg::count_idx)) begin
					prdata <= {16'h0000, count_value_q};
				end else if (hit(paddr, timer_pkg::capcmp_a_idx)) begin
					prdata <= {16'h0000, capcmp_a_q};
				end else if (hit(paddr, timer_pkg::capcmp_b_idx)) begin
					prdata <= {16'h0000, capcmp_b_q};
				end else if (hit(paddr, timer_pkg::edge_sel_idx)) begin
					prdata <= {24'h000000, edge_b_sel_q, edge_a_sel_q, 4'h0};
				end else begin
					prdata <= timer_pkg::rdata_reset;
				end
			end else begin
				prdata <= timer_pkg::rdata_reset;
			end
		end
	end

	// Checks on the counting, capture and interrupt behaviour.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_stop_no_count: assert property (!running |=> count_value_q == 16'h0000)
		else $error("counter moved while stopped");
	chk_stop_no_irq: assert property (!running [*3] |-> capcmp_irq == 2'b00)
		else $error("interrupt raised while stopped");
	chk_free_wrap: assert property ((mode_q.mode == timer_pkg::mode_free) && running
		&& !wr_sel[0] |=> count_value_q == $past(count_value_q) + 16'h0001)
		else $error("free-run count did not advance by one");
	chk_edge_clear: assert property ((mode_q.mode == timer_pkg::mode_edge) && evt_a.valid
		&& !wr_sel[0] |=> count_value_q == 16'h0000)
		else $error("edge did not clear the counter");
	chk_match_clear: assert property ((mode_q.mode == timer_pkg::mode_match) && match_a
		&& !wr_sel[0] |=> count_value_q == 16'h0000)
		else $error("match did not clear the counter");
	chk_out_toggle: assert property (toggle_ev |=> timer_out_pin != $past(timer_out_pin))
		else $error("output failed to toggle");
	chk_cmp_irq: assert property (match_a && running ##1 running [*2] |-> capcmp_irq[0])
		else $error("compare match gave no interrupt");
	chk_cap_store: assert property (cap_b |=> capcmp_b_q == $past(count_value_q))
		else $error("capture did not store the count");
	chk_cap_irq_lag: assert property (cap_b ##1 running [*2] |-> capcmp_irq[1])
		else $error("capture interrupt not one count clock later");
	chk_ovf_set: assert property (wrap_ovf |=> mode_q.overflow_flag)
		else $error("overflow flag not set on wrap");
	chk_ovf_reset_hold: assert property (ovf_window_q |=> mode_q.overflow_flag)
		else $error("overflow clear took effect too early");
	chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single access-phase pulse");

	cov_free_wrap: cover property (wrap_ovf ##1 count_value_q == 16'h0000);
	cov_capture_a: cover property (cap_a ##2 capcmp_irq[0]);
	cov_edge_clear: cover property ((mode_q.mode == timer_pkg::mode_edge) && evt_a.valid);
	cov_toggle: cover property (toggle_ev ##1 toggle_ev);
endmodule
`default_nettype wire

// >>> verilog/timer_pkg.sv
// Package with register map, field layout and types of the timer mode and capture block.
package timer_pkg;

	// Register indices as printed; the APB byte address is four times the index.
	localparam logic [15:0] mode_ctl_idx     = 16'hff60;
	localparam logic [15:0] capcmp_ctl_idx   = 16'hff62;
	localparam logic [15:0] count_idx        = 16'hff64;
	localparam logic [15:0] capcmp_a_idx     = 16'hff65;
	localparam logic [15:0] capcmp_b_idx     = 16'hff66;
	localparam logic [15:0] edge_sel_idx     = 16'hff67;
	localparam int          addr_shift       = 2;

	// Field positions.
	localparam int ovf_pos          = 0;
	localparam int out_toggle_pos   = 1;
	localparam int mode_lo_pos      = 2;
	localparam int cc_a_mode_pos    = 0;
	localparam int cc_a_trig_pos    = 1;
	localparam int cc_b_mode_pos    = 2;
	localparam int edge_a_pos       = 4;
	localparam int edge_b_pos       = 6;

	// Values after reset.
	localparam logic [7:0]  ctl_reset        = 8'h00;
	localparam logic [15:0] word_reset       = 16'h0000;
	localparam logic [15:0] count_max        = 16'hffff;
	localparam logic [15:0] count_one        = 16'h0001;
	localparam logic [31:0] rdata_reset      = 32'h0000_0000;

	// Count-clock latency: capture on one count clock, interrupt on the next.
	localparam int irq_lag_cycles = 1;

	// Operating mode held in the two upper mode bits.
	typedef enum logic [1:0] {
		mode_stop  = 2'b00,
		mode_free  = 2'b01,
		mode_edge  = 2'b10,
		mode_match = 2'b11
	} mode_type;

	// Valid-edge selection of an input pin.
	typedef enum logic [1:0] {
		edge_fall = 2'b00,
		edge_rise = 2'b01,
		edge_bad  = 2'b10,
		edge_both = 2'b11
	} edge_sel_type;

	// Mode control register contents.
	typedef struct packed {
		mode_type mode;
		logic     out_toggle_sel;
		logic     overflow_flag;
	} mode_ctl_type;

	// Capture/compare control register contents.
	typedef struct packed {
		logic capcmp_b_mode;
		logic capcmp_a_trig_sel;
		logic capcmp_a_mode;
	} capcmp_ctl_type;

	// Qualified edge pulses from one input pin.
	typedef struct packed {
		logic valid;
		logic opposite;
	} edge_evt_type;

endpackage
